// ==== pkg/acs_defines.svh ====
// constants of the dual channel sequencer: modes, timing, result window
// assumes nothing beyond a 10 MHz system clock
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_MODE_CONT 2'h0
`define ACS_MODE_SINGLE 2'h1
`define ACS_MODE_SYNC 2'h2
`define ACS_CLK_NS 100
`define ACS_SETTLE_UNIT_NS 1000
`define ACS_SETTLE_UNIT_CYC ((`ACS_SETTLE_UNIT_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_RESULT_RESET 16'h0000
`define ACS_RES_A_BASE 8'h10
`define ACS_RES_B_BASE 8'h20
`define ACS_RES_LAST 8'h2F
`endif

// ==== pkg/acs_link_if.sv ====
// link between one channel controller, its settle timer and result bank
// assumes one clock shared by all three
`timescale 1ns/1ps
`default_nettype none
interface acs_link_if;
   logic tmr_load;
   logic [2:0] tmr_sel;
   logic tmr_done;
   logic wr;
   logic [3:0] wr_step;
   logic [15:0] wr_data;
   logic commit;
   logic [15:0] commit_mask;
   logic clear;
   logic [3:0] rd_step;
   logic [15:0] rd_data;
   modport ctrl (output tmr_load, tmr_sel, wr, wr_step, wr_data, commit, commit_mask, clear,
      rd_step, input tmr_done, rd_data);
   modport timer (input tmr_load, tmr_sel, output tmr_done);
   modport bank (input wr, wr_step, wr_data, commit, commit_mask, clear, rd_step,
      output rd_data);
endinterface
`default_nettype wire

// ==== pkg/acs_pkg.sv ====
// types and helpers of the dual channel sequencer
// assumes acs_defines.svh is on the include path
`include "acs_defines.svh"
package acs_pkg;
   typedef enum logic [1:0] {ACS_IDLE, ACS_SETTLE, ACS_CONVERT} acs_state_e;
   typedef struct packed {
      acs_state_e state;
      logic [3:0] step;
      logic [15:0] run_en;
      logic armed;
      logic halt_pend;
      logic conv_start;
      logic [15:0] conv_cfg;
   } acs_chan_s;
   typedef struct packed {
      acs_chan_s [1:0] ch;
      logic [15:0] rd_data;
   } acs_top_s;
   typedef struct packed {
      logic busy;
      logic done;
      logic [11:0] cnt;
   } acs_timer_s;
   typedef struct packed {
      logic [15:0][15:0] shadow;
      logic [15:0][15:0] live;
   } acs_bank_s;

   // first enabled step at or above from; bit 4 flags a hit
   function automatic logic [4:0] acs_find(input logic [15:0] en, input logic [4:0] from);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 15; i >= 0; i--)
      begin
         if (en[i] && (5'(i) >= from))
            r = {1'b1, 4'(i)};
      end
      return r;
   endfunction

   // widens a step mask to one 16-bit lane per step
   function automatic logic [15:0][15:0] acs_keep(input logic [15:0] m);
      logic [15:0][15:0] r;
      r = '0;
      for (int i = 0; i < 16; i++)
         r[i] = {16{m[i]}};
      return r;
   endfunction
endpackage

// ==== rtl/acs_result_bank.sv ====
// per-channel results: a shadow bank filled during a run, copied all at once,
// disabled steps zeroed, into the readable bank at run end; assumes one clock
`timescale 1ns/1ps
`default_nettype none
module acs_result_bank
   import acs_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   acs_link_if.bank lnk // writes, commit, clear and read
);
   acs_bank_s st_reg;
   acs_bank_s st_next;

   always_comb
   begin
      st_next = st_reg;
      if (lnk.wr)
         st_next.shadow[lnk.wr_step] = lnk.wr_data;
      if (lnk.clear)
         st_next.live = '0;
      else if (lnk.commit)
         st_next.live = st_next.shadow & acs_keep(lnk.commit_mask);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign lnk.rd_data = st_reg.live[lnk.rd_step];

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_clear_zeroes: assert property (lnk.clear |=> st_reg.live == '0)
      else $error("results not cleared");
   a_disabled_zero: assert property (
      lnk.commit && !lnk.clear |=> (st_reg.live & ~acs_keep($past(lnk.commit_mask))) == '0)
      else $error("disabled step result not zero");
   a_live_frozen: assert property (
      !lnk.commit && !lnk.clear |=> $stable(st_reg.live))
      else $error("results changed outside run end");
endmodule
`default_nettype wire

// ==== rtl/acs_settle_timer.sv ====
// settling delay counter: load starts it, done pulses after the delay
// assumes load is a one-cycle pulse from the channel controller
`timescale 1ns/1ps
`default_nettype none
module acs_settle_timer
   import acs_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   acs_link_if.timer lnk // load, select and done
);
   acs_timer_s st_reg;
   acs_timer_s st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (lnk.tmr_load)
      begin
         st_next.busy = 1'b1;
         st_next.cnt = (12'(`ACS_SETTLE_UNIT_CYC) << lnk.tmr_sel) - 12'h001;
      end
      else if (st_reg.busy)
      begin
         if (st_reg.cnt == 12'h001)
         begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
         end
         else
            st_next.cnt = st_reg.cnt - 12'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign lnk.tmr_done = st_reg.done;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_settle_shortest: assert property (
      lnk.tmr_load && lnk.tmr_sel == 3'h0 ##1 !lnk.tmr_load [*8] ##1 !lnk.tmr_load
      |=> lnk.tmr_done)
      else $error("settle delay for select 0 is not ten cycles");
   a_settle_no_early: assert property (
      lnk.tmr_load |=> !lnk.tmr_done [*8])
      else $error("settle done arrived too early");
endmodule
`default_nettype wire

// ==== rtl/acs_top.sv ====
// two independent sequencers for the secondary converters A and B
// assumes control strobes come from the serial block on CLK_SYS
// Behaviour
// - sixteen steps, each enabled step converts exactly once per run.
// - each step's gain and input selection go to the converter first.
// - runs start at step 0 and climb, skipping disabled steps.
// - a settling delay, chosen by one 3-bit field, precedes each conversion.
// - running flag is high exactly while a run is in progress.
// - launch while the converter is disabled is ignored.
// - 16-bit step results readable in the window 10h to 2Fh.
// - on run completion disabled steps read zero.
// - all results update together at run end, never mixing runs.
// - two-bit mode picks continuous, single-shot or primary-synchronized.
// - continuous mode repeats runs back to back until halted.
// - launch during a run in continuous or single mode restarts it.
// - halt in continuous mode finishes the run; halt reads one until stopped.
// - disable, standby or power-down aborts the run at once.
// - launch and halt together: launch wins.
// - results persist; cleared only by reset, disable or sleep.
// - single-shot: one run per launch, halt does nothing.
// - synchronized: primary start triggers a run only when idle.
// - launch takes effect at the CRC word's last serial clock edge.
`timescale 1ns/1ps
`default_nettype none
module acs_top
   import acs_pkg::*;
(
   input wire logic CLK_SYS, // system clock, 10 MHz
   input wire logic RESET_N, // async reset, active low
   input wire logic [1:0] SEQ_LAUNCH, // launch pulse per channel
   input wire logic [1:0] SEQ_HALT, // halt pulse per channel
   input wire logic [1:0][1:0] SEQ_MODE_SEL, // sequence mode per channel
   input wire logic [1:0] SECONDARY_CONV_ENABLE, // converter enable per channel
   input wire logic DEVICE_SLEEP, // standby or power-down
   input wire logic [1:0][15:0] STEP_ENABLE, // step enables per channel
   input wire logic [1:0][2:0] SETTLE_DELAY_SEL, // settle delay select
   input wire logic [1:0][15:0][15:0] STEP_INPUT_CONFIG, // per-step gain and inputs
   input wire logic [1:0] PRIMARY_LAUNCH, // primary conversion start pulse
   output logic [1:0] CONV_START, // conversion start pulse
   output logic [1:0][15:0] CONV_CFG, // gain and input selection
   input wire logic [1:0] CONV_DONE, // conversion done pulse
   input wire logic [1:0][15:0] CONV_DATA, // conversion result
   output logic [1:0] SEQ_RUNNING_FLAG, // run in progress
   output logic [1:0] SEQ_HALT_PENDING, // halt bit readback
   input wire logic [7:0] RESULT_RD_ADDR, // result read address
   output logic [15:0] RESULT_RD_DATA // result read data
);
   acs_top_s st_reg;
   acs_top_s st_next;
   logic [1:0] tmr_load;
   logic [1:0] tmr_done;
   logic [1:0] bank_wr;
   logic [1:0] bank_commit;
   logic [1:0] bank_clear;
   logic [1:0][3:0] wr_step;
   logic [1:0][15:0] wr_data;
   logic [1:0][15:0] commit_mask;
   logic [1:0][15:0] rd_data;

   for (genvar g = 0; g < 2; g++)
   begin : g_ch
      // one full sequencer per converter
      acs_link_if lnk();
      assign lnk.tmr_load = tmr_load[g];
      assign lnk.tmr_sel = SETTLE_DELAY_SEL[g];
      assign lnk.wr = bank_wr[g];
      assign lnk.wr_step = wr_step[g];
      assign lnk.wr_data = wr_data[g];
      assign lnk.commit = bank_commit[g];
      assign lnk.commit_mask = commit_mask[g];
      assign lnk.clear = bank_clear[g];
      assign lnk.rd_step = RESULT_RD_ADDR[3:0];
      assign tmr_done[g] = lnk.tmr_done;
      assign rd_data[g] = lnk.rd_data;

      acs_settle_timer u_timer (
         .clk(CLK_SYS),
         .rst_n(RESET_N),
         .lnk(lnk)
      );

      acs_result_bank u_bank (
         .clk(CLK_SYS),
         .rst_n(RESET_N),
         .lnk(lnk)
      );

      assign CONV_START[g] = st_reg.ch[g].conv_start;
      assign CONV_CFG[g] = st_reg.ch[g].conv_cfg;
      assign SEQ_RUNNING_FLAG[g] = (st_reg.ch[g].state != ACS_IDLE);
      assign SEQ_HALT_PENDING[g] = st_reg.ch[g].halt_pend;
   end

   always_comb
   begin
      logic [4:0] f;
      logic go;
      logic on;
      f = 5'h00;
      go = 1'b0;
      on = 1'b0;
      st_next = st_reg;
      tmr_load = '0;
      bank_wr = '0;
      bank_commit = '0;
      bank_clear = '0;
      wr_step = '0;
      wr_data = '0;
      commit_mask = '0;
      for (int c = 0; c < 2; c++)
      begin
         st_next.ch[c].conv_start = 1'b0;
         go = 1'b0;
         on = SECONDARY_CONV_ENABLE[c] && !DEVICE_SLEEP;
         if (!on)
         begin
            // abort mid-step, drop arming and results
            st_next.ch[c].state = ACS_IDLE;
            st_next.ch[c].armed = 1'b0;
            st_next.ch[c].halt_pend = 1'b0;
            bank_clear[c] = 1'b1;
         end
         else
         begin
            if (SEQ_LAUNCH[c])
            begin
               st_next.ch[c].halt_pend = 1'b0;
               if (SEQ_MODE_SEL[c] == `ACS_MODE_SYNC)
               begin
                  st_next.ch[c].armed = 1'b1;
                  go = (st_reg.ch[c].state == ACS_IDLE);
               end
               else
                  go = 1'b1;
            end
            else if (SEQ_HALT[c] && SEQ_MODE_SEL[c] == `ACS_MODE_CONT &&
               st_reg.ch[c].state != ACS_IDLE)
               st_next.ch[c].halt_pend = 1'b1;
            else if (SEQ_MODE_SEL[c] == `ACS_MODE_SYNC && st_reg.ch[c].armed &&
               PRIMARY_LAUNCH[c] && st_reg.ch[c].state == ACS_IDLE)
               go = 1'b1;

            if (!go)
            begin
               case (st_reg.ch[c].state)
                  ACS_SETTLE:
                  begin
                     if (tmr_done[c])
                     begin
                        st_next.ch[c].conv_start = 1'b1;
                        st_next.ch[c].state = ACS_CONVERT;
                     end
                  end
                  ACS_CONVERT:
                  begin
                     if (CONV_DONE[c])
                     begin
                        bank_wr[c] = 1'b1;
                        wr_step[c] = st_reg.ch[c].step;
                        wr_data[c] = CONV_DATA[c];
                        f = acs_find(st_reg.ch[c].run_en, {1'b0, st_reg.ch[c].step} + 5'h01);
                        if (f[4])
                        begin
                           st_next.ch[c].step = f[3:0];
                           st_next.ch[c].conv_cfg = STEP_INPUT_CONFIG[c][f[3:0]];
                           st_next.ch[c].state = ACS_SETTLE;
                           tmr_load[c] = 1'b1;
                        end
                        else
                        begin
                           bank_commit[c] = 1'b1;
                           commit_mask[c] = st_reg.ch[c].run_en;
                           if (SEQ_MODE_SEL[c] == `ACS_MODE_CONT && !st_next.ch[c].halt_pend)
                              go = 1'b1;
                           else
                           begin
                              st_next.ch[c].state = ACS_IDLE;
                              st_next.ch[c].halt_pend = 1'b0;
                           end
                        end
                     end
                  end
                  default:
                  begin
                  end
               endcase
            end

            if (go)
            begin
               // a fresh run from the lowest enabled step
               st_next.ch[c].run_en = STEP_ENABLE[c];
               f = acs_find(STEP_ENABLE[c], 5'h00);
               if (f[4])
               begin
                  st_next.ch[c].step = f[3:0];
                  st_next.ch[c].conv_cfg = STEP_INPUT_CONFIG[c][f[3:0]];
                  st_next.ch[c].state = ACS_SETTLE;
                  tmr_load[c] = 1'b1;
               end
               else
               begin
                  // nothing enabled: publish all zeros and stop
                  st_next.ch[c].state = ACS_IDLE;
                  st_next.ch[c].halt_pend = 1'b0;
                  bank_commit[c] = 1'b1;
                  commit_mask[c] = 16'h0000;
               end
            end
         end
      end

      st_next.rd_data = `ACS_RESULT_RESET;
      if (RESULT_RD_ADDR >= `ACS_RES_A_BASE && RESULT_RD_ADDR < `ACS_RES_B_BASE)
         st_next.rd_data = rd_data[0];
      else if (RESULT_RD_ADDR >= `ACS_RES_B_BASE && RESULT_RD_ADDR <= `ACS_RES_LAST)
         st_next.rd_data = rd_data[1];
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign RESULT_RD_DATA = st_reg.rd_data;

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   for (genvar g = 0; g < 2; g++)
   begin : g_chk
      sequence s_busy;
         SEQ_RUNNING_FLAG[g] && st_reg.ch[g].state == ACS_CONVERT;
      endsequence
      sequence s_relaunch;
         SEQ_LAUNCH[g] && SECONDARY_CONV_ENABLE[g] && !DEVICE_SLEEP &&
            SEQ_MODE_SEL[g] != `ACS_MODE_SYNC && STEP_ENABLE[g][0];
      endsequence

      a_launch_ignored: assert property (
         SEQ_LAUNCH[g] && !SECONDARY_CONV_ENABLE[g] |=> !SEQ_RUNNING_FLAG[g])
         else $error("launch while disabled started a run");
      a_abort_now: assert property (
         SEQ_RUNNING_FLAG[g] && DEVICE_SLEEP |=> !SEQ_RUNNING_FLAG[g] && !SEQ_HALT_PENDING[g])
         else $error("sleep did not abort the run");
      a_start_step0: assert property (
         s_relaunch |=> SEQ_RUNNING_FLAG[g] && st_reg.ch[g].step == 4'h0 ##9 !CONV_START[g])
         else $error("run did not start at step zero");
      a_restart_run: assert property (
         s_busy ##0 s_relaunch |=> st_reg.ch[g].state == ACS_SETTLE && st_reg.ch[g].step == 4'h0)
         else $error("launch did not restart the run");
      a_halt_holds: assert property (
         SEQ_HALT[g] && !SEQ_LAUNCH[g] && !CONV_DONE[g] && SEQ_RUNNING_FLAG[g] &&
            SECONDARY_CONV_ENABLE[g] && !DEVICE_SLEEP && SEQ_MODE_SEL[g] == `ACS_MODE_CONT
         |=> SEQ_HALT_PENDING[g] && SEQ_RUNNING_FLAG[g])
         else $error("halt did not let the run continue");
      a_single_halt: assert property (
         SEQ_MODE_SEL[g] == `ACS_MODE_SINGLE && !SEQ_HALT_PENDING[g] |=> !SEQ_HALT_PENDING[g])
         else $error("halt had an effect in single-shot mode");
      a_sync_keeps: assert property (
         SEQ_MODE_SEL[g] == `ACS_MODE_SYNC && SEQ_RUNNING_FLAG[g] && PRIMARY_LAUNCH[g] &&
            !SEQ_LAUNCH[g] && !CONV_DONE[g] && SECONDARY_CONV_ENABLE[g] && !DEVICE_SLEEP
         |=> SEQ_RUNNING_FLAG[g] && $stable(st_reg.ch[g].step))
         else $error("primary start disturbed a running sequence");
      a_conv_settled: assert property (
         CONV_START[g] |-> $past(tmr_done[g]) && st_reg.ch[g].state == ACS_CONVERT)
         else $error("conversion started before settling");
      a_flag_on_start: assert property (
         tmr_load[g] |=> SEQ_RUNNING_FLAG[g] ##1 (SEQ_RUNNING_FLAG[g] ||
            $past(DEVICE_SLEEP || !SECONDARY_CONV_ENABLE[g]) ||
            $past(SEQ_LAUNCH[g] && STEP_ENABLE[g] == 16'h0000)))
         else $error("running flag low during a run");
   end
endmodule
`default_nettype wire

// ==== sim/acs_conv_model.sv ====
// behavioural secondary converter with its input multiplexer
// assumes start is a one-cycle pulse and lat stays at 1 or more
`timescale 1ns/1ps
`default_nettype none
module acs_conv_model (
   input wire logic clk, // system clock
   input wire logic rst_n, // reset, active low
   input wire logic start, // conversion start pulse
   input wire logic [15:0] cfg, // applied gain and inputs
   input wire logic [7:0] lat, // cycles from start to done
   output logic done, // done pulse, data valid with it
   output logic [15:0] data // conversion result
);
   logic [7:0] cnt;
   logic busy;
   logic [15:0] held;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy <= 1'b0;
         cnt <= 8'h00;
         done <= 1'b0;
         data <= 16'h0000;
         held <= 16'h0000;
      end
      else
      begin
         done <= 1'b0;
         data <= ~data; // nothing valid outside the done pulse
         if (start)
         begin
            // a new start drops any conversion still in flight
            busy <= 1'b1; // one conversion per start
            cnt <= lat;
            held <= cfg ^ 16'h5A5A; // result follows the applied input
         end
         else if (busy && cnt <= 8'h01)
         begin
            busy <= 1'b0;
            done <= 1'b1;
            data <= held;
         end
         else if (busy)
            cnt <= cnt - 8'h01;
      end
   end
endmodule
`default_nettype wire

// ==== sim/acs_top_tb_top.sv ====
// self-checking bench of the dual sequencer with two converter models
// assumes acs_defines.svh on the include path, package compiled first
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
`define ACS_CHK(nm, e, g) \
   begin total_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module acs_top_tb_top;
   import acs_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic sleep = 1'b0;
   logic [1:0] launch = '0, halt = '0, conv_en = 2'b11, prim = '0;
   logic [1:0] conv_start, conv_done, running, halt_pend;
   logic [1:0][1:0] mode = '0;
   logic [1:0][15:0] step_en = '0, conv_cfg, conv_data;
   logic [1:0][2:0] sel = '0;
   logic [1:0][15:0][15:0] cfg = '0, exp_res = '0;
   logic [1:0][7:0] lat = {8'h04, 8'h04};
   logic [7:0] rd_addr = 8'h00;
   logic [15:0] rd_data;
   logic [15:0][15:0] seq_list [2];
   int n_list [2] = '{1, 1};
   int ptr [2] = '{0, 0};
   int cyc [2] = '{0, 0};
   int nstart [2] = '{0, 0};
   int miscompares = 0;
   int total_checks = 0;
   acs_top acs_top_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SEQ_LAUNCH(launch),
      .SEQ_HALT(halt), .SEQ_MODE_SEL(mode), .SECONDARY_CONV_ENABLE(conv_en),
      .DEVICE_SLEEP(sleep), .STEP_ENABLE(step_en), .SETTLE_DELAY_SEL(sel),
      .STEP_INPUT_CONFIG(cfg), .PRIMARY_LAUNCH(prim), .CONV_START(conv_start),
      .CONV_CFG(conv_cfg), .CONV_DONE(conv_done), .CONV_DATA(conv_data),
      .SEQ_RUNNING_FLAG(running), .SEQ_HALT_PENDING(halt_pend),
      .RESULT_RD_ADDR(rd_addr), .RESULT_RD_DATA(rd_data));
   for (genvar g = 0; g < 2; g++)
   begin : g_conv
      acs_conv_model acs_conv_model_i (.clk(clk_sys), .rst_n(reset_n), .start(conv_start[g]),
         .cfg(conv_cfg[g]), .lat(lat[g]), .done(conv_done[g]), .data(conv_data[g]));
   end
   always #50 clk_sys = ~clk_sys;
   // step order and settle spacing seen at every conversion start
   always @(posedge clk_sys)
   begin
      for (int c = 0; c < 2; c++)
      begin
         cyc[c]++;
         if (conv_start[c])
         begin
            `ACS_CHK("conv_cfg", seq_list[c][ptr[c] % 16], conv_cfg[c])
            `ACS_CHK("settle", 1 + `ACS_SETTLE_UNIT_CYC * (1 << sel[c]), cyc[c])
            `ACS_CHK("run_flag", 1'b1, running[c])
            ptr[c] = (ptr[c] + 1) % n_list[c];
            nstart[c]++;
         end
         if (conv_done[c])
            cyc[c] = 0;
         if ((launch[c] && conv_en[c] && !sleep)
            || (prim[c] && !running[c] && mode[c] == `ACS_MODE_SYNC))
         begin
            cyc[c] = 0;
            ptr[c] = 0;
         end
      end
   end
   task automatic tally_and_finish();
      if (miscompares == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tick(int n = 1);
      repeat (n)
      begin
         @(posedge clk_sys);
         #1;
         launch = '0;
         halt = '0;
         prim = '0;
      end
   endtask
   function automatic logic [15:0] res_of(int c, int i);
      return step_en[c][i] ? (cfg[c][i] ^ 16'h5A5A) : 16'h0000;
   endfunction
   task automatic set_up(int c, logic [15:0] en, logic [1:0] m, logic [2:0] s);
      conv_en[c] = 1'b0;
      tick();
      step_en[c] = en;
      mode[c] = m;
      sel[c] = s;
      lat[c] = 8'($urandom_range(1, 12));
      n_list[c] = 0;
      for (int i = 0; i < 16; i++)
      begin
         cfg[c][i] = 16'($urandom);
         if (en[i])
         begin
            seq_list[c][n_list[c]] = cfg[c][i];
            n_list[c]++;
         end
      end
      conv_en[c] = 1'b1;
      exp_res[c] = '0;
      tick();
   endtask
   task automatic finish_run(int c);
      for (int w = 0; w < 40000 && running[c] !== 1'b0; w++)
         tick();
      `ACS_CHK("run_end", 1'b0, running[c])
      for (int i = 0; i < 16; i++)
         exp_res[c][i] = res_of(c, i);
   endtask
   task automatic wait_starts(int c, int target);
      for (int w = 0; w < 20000 && nstart[c] < target; w++)
         tick();
   endtask
   task automatic check_bank(int c);
      for (int i = 0; i < 16; i++)
      begin
         rd_addr = 8'(`ACS_RES_A_BASE + 16 * c + i);
         tick();
         `ACS_CHK("result", exp_res[c][i], rd_data)
      end
   endtask
   initial
   begin
      int b;
      void'($urandom(32'h7909));
      tick(16);
      reset_n = 1'b1;
      tick();
      `ACS_CHK("idle_flag", 2'b00, running)
      rd_addr = 8'h0F;
      tick();
      `ACS_CHK("unmapped", 16'h0000, rd_data)
      check_bank(0);
      check_bank(1);
      // single runs, random enables, settle selects 0 to 3
      for (int k = 0; k < 8; k++)
      begin
         set_up(k % 2, (k == 0) ? 16'hFFFF : (k == 1) ? 16'h8001 : 16'($urandom) | 16'h0010,
            (k % 3 == 2) ? 2'h3 : `ACS_MODE_SINGLE, 3'(k % 4));
         launch[k % 2] = 1'b1;
         tick();
         `ACS_CHK("run_flag", 1'b1, running[k % 2])
         rd_addr = 8'(`ACS_RES_A_BASE + 16 * (k % 2) + 4);
         tick(2);
         `ACS_CHK("old_result", exp_res[k % 2][4], rd_data)
         b = nstart[k % 2];
         finish_run(k % 2);
         `ACS_CHK("steps", n_list[k % 2], nstart[k % 2] - b)
         check_bank(0);
         check_bank(1);
      end
      // restart by launch with halt, then halt ignored in single mode
      set_up(0, 16'h0F0F, `ACS_MODE_SINGLE, 3'h1);
      launch[0] = 1'b1;
      tick(5);
      launch[0] = 1'b1;
      halt[0] = 1'b1;
      b = nstart[0];
      tick(30);
      halt[0] = 1'b1;
      tick();
      `ACS_CHK("halt_single", 1'b0, halt_pend[0])
      finish_run(0);
      `ACS_CHK("restart_steps", n_list[0], nstart[0] - b)
      check_bank(0);
      // continuous: second run finishes after halt
      set_up(1, 16'($urandom) | 16'h0003, `ACS_MODE_CONT, 3'h0);
      b = nstart[1];
      launch[1] = 1'b1;
      tick();
      wait_starts(1, b + n_list[1] + 1);
      rd_addr = 8'(`ACS_RES_B_BASE + 1);
      tick(2);
      `ACS_CHK("first_run", res_of(1, 1), rd_data)
      halt[1] = 1'b1;
      tick();
      `ACS_CHK("halt_pend", 2'b11, {halt_pend[1], running[1]})
      finish_run(1);
      `ACS_CHK("halt_clear", 1'b0, halt_pend[1])
      `ACS_CHK("cont_steps", 2 * n_list[1], nstart[1] - b)
      check_bank(1);
      // synchronized: primary ignored mid-run, taken when idle
      set_up(1, 16'h1248, `ACS_MODE_SYNC, 3'h0);
      launch[1] = 1'b1;
      prim[1] = 1'b1;
      tick(20);
      b = nstart[1];
      prim[1] = 1'b1;
      finish_run(1);
      `ACS_CHK("sync_steps", n_list[1] - 1, nstart[1] - b)
      tick(30);
      `ACS_CHK("sync_no_restart", 1'b0, running[1])
      prim[1] = 1'b1;
      tick();
      `ACS_CHK("sync_trigger", 1'b1, running[1])
      finish_run(1);
      check_bank(1);
      // abort by disable and sleep; launch while disabled
      set_up(0, 16'hFFFF, `ACS_MODE_CONT, 3'h0);
      launch[0] = 1'b1;
      tick(40);
      conv_en[0] = 1'b0;
      tick();
      `ACS_CHK("disable_abort", 1'b0, running[0])
      launch[0] = 1'b1;
      tick(3);
      `ACS_CHK("disabled_launch", 1'b0, running[0])
      exp_res[0] = '0;
      check_bank(0);
      check_bank(1);
      conv_en[0] = 1'b1;
      set_up(1, 16'hFFFF, `ACS_MODE_CONT, 3'h0);
      launch[1] = 1'b1;
      tick(30);
      sleep = 1'b1;
      tick();
      `ACS_CHK("sleep_abort", 2'b00, running)
      sleep = 1'b0;
      exp_res = '0;
      check_bank(0);
      check_bank(1);
      tally_and_finish();
   end
   initial
   begin
      #8_000_000;
      miscompares++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
